// ===== sim/pfl_bank_monitor.sv
// concurrent checks on the fault-limit command bank ports
// assumes: one clock domain, synchronous active-high reset, bound to pfl_bank
`timescale 1ns/1ns
`default_nettype none
module pfl_bank_monitor #(
  parameter int DATA_W = 16  // command data width
) (
  input wire logic              ref_clk,
  input wire logic              reset,
  input wire logic              cmd_wr,
  input wire logic              cmd_rd,
  input wire logic [DATA_W-1:0] cmd_rdata_q,
  input wire logic              cmd_ack_q,
  input wire logic              cmd_nack_q,
  input wire logic              enable_pin,
  input wire logic              bias_ok_pin,
  input wire logic              operation_on,
  input wire logic              other_fault,
  input wire logic              clear_faults,
  input wire logic              output_en_q,
  input wire logic              ot_fault_q,
  input wire logic              vin_ov_fault_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ============================================================
  // shutdown causes; pins need two sync flops plus sequencer and output edges
  sequence strobe_s; cmd_wr || cmd_rd; endsequence
  sequence bias_gone_s; !bias_ok_pin [*5]; endsequence
  sequence en_gone_s; !enable_pin [*5]; endsequence
  sequence op_gone_s; !operation_on [*3]; endsequence
  sequence other_s; other_fault [*3]; endsequence
  // ============================================================
  // command port and sequencer relations
  ack_once_a: assert property (strobe_s |=> cmd_ack_q ^ cmd_nack_q)
    else $error("access not answered by exactly one of ack or nack");
  ack_quiet_a: assert property (!(cmd_wr || cmd_rd) |=> !cmd_ack_q && !cmd_nack_q)
    else $error("answer without an access");
  rdata_hold_a: assert property (!cmd_rd |=> $stable(cmd_rdata_q))
    else $error("read data moved without a read");
  ot_off_a: assert property (ot_fault_q |-> !output_en_q)
    else $error("output on during over-temperature");
  vin_hold_a: assert property (vin_ov_fault_q && !clear_faults |=> vin_ov_fault_q)
    else $error("input over-voltage flag dropped without clear");
  vin_norestart_a: assert property ($rose(output_en_q) |-> !vin_ov_fault_q)
    else $error("output restarted with input over-voltage latched");
  bias_off_a: assert property (bias_gone_s |-> !output_en_q)
    else $error("output on without bias");
  other_off_a: assert property (other_s |-> !output_en_q)
    else $error("output on during another fault");
  en_off_a: assert property (en_gone_s |-> !output_en_q)
    else $error("output on with enable pin low");
  op_off_a: assert property (op_gone_s |-> !output_en_q)
    else $error("output on with operation off");
endmodule
bind pfl_bank pfl_bank_monitor #(.DATA_W(DATA_W)) pfl_bank_monitor_i (
  .ref_clk(ref_clk), .reset(reset), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
  .cmd_rdata_q(cmd_rdata_q), .cmd_ack_q(cmd_ack_q), .cmd_nack_q(cmd_nack_q),
  .enable_pin(enable_pin), .bias_ok_pin(bias_ok_pin), .operation_on(operation_on),
  .other_fault(other_fault), .clear_faults(clear_faults), .output_en_q(output_en_q),
  .ot_fault_q(ot_fault_q), .vin_ov_fault_q(vin_ov_fault_q));
`default_nettype wire

// ===== sim/pfl_bank_tb_top.sv
// self-checking bench for the fault-limit command bank
// assumes: host model drives the command port; bench drives pins and telemetry
`timescale 1ns/1ns
`default_nettype none
module pfl_bank_tb_top;
  logic ref_clk = 1'b0;  // 25 MHz
  logic reset = 1'b1;
  logic enable_pin = 0, bias_ok_pin = 1, vin_ov_detect = 0;
  logic operation_on = 0, other_fault = 0, clear_faults = 0;
  logic [15:0] temp_reading = 16'h0019, vout_reading = 16'h0000;
  wire logic [7:0] cmd_code;
  wire logic cmd_wr, cmd_rd, cmd_ack_q, cmd_nack_q;
  wire logic [15:0] cmd_wdata, cmd_rdata_q;
  wire logic output_en_q, power_good_q, ot_fault_q, ot_warn_q, vin_ov_fault_q;
  int fail_count = 0;
  int n_checks = 0;
  logic ak, nk;
  logic [15:0] q;
  logic [7:0] codes [12] = '{8'h4a, 8'h4f, 8'h50, 8'h51, 8'h55, 8'h56, 8'h58, 8'h5d, 8'h5e, 8'h5f, 8'h60, 8'h61};
  logic [15:0] defs [12] = '{16'h0000, 16'h007d, 16'h00f9, 16'h0069, 16'hf81e, 16'h00b8,
                             16'hf812, 16'hf80a, 16'h0114, 16'h0105, 16'h0000, 16'h0005};
  logic [7:0] otc [8] = '{8'h22, 8'h36, 8'hc0, 8'hd6, 8'he2, 8'hf6, 8'hf9, 8'hf8};
  logic [7:0] vic [10] = '{8'h00, 8'h16, 8'h22, 8'h36, 8'hc0, 8'hd6, 8'he2, 8'hf6, 8'hb8, 8'h99};
  logic [7:0] anyc [4] = '{8'h4a, 8'h58, 8'h5d, 8'h60};
  always #20 ref_clk = ~ref_clk;
  pfl_host pfl_host_i (.ref_clk(ref_clk), .cmd_ack_q(cmd_ack_q), .cmd_nack_q(cmd_nack_q),
    .cmd_rdata_q(cmd_rdata_q), .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata));
  pfl_bank pfl_bank_i (.ref_clk(ref_clk), .reset(reset), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata), .cmd_rdata_q(cmd_rdata_q), .cmd_ack_q(cmd_ack_q),
    .cmd_nack_q(cmd_nack_q), .enable_pin(enable_pin), .bias_ok_pin(bias_ok_pin),
    .vin_ov_detect(vin_ov_detect), .operation_on(operation_on), .other_fault(other_fault),
    .clear_faults(clear_faults), .temp_reading(temp_reading), .vout_reading(vout_reading),
    .output_en_q(output_en_q), .power_good_q(power_good_q), .ot_fault_q(ot_fault_q),
    .ot_warn_q(ot_warn_q), .vin_ov_fault_q(vin_ov_fault_q));
  // ============================================================
  // expectation helpers: accepted values per register
  function automatic logic lim_ok(input logic [15:0] v);
    return v <= 16'h0096;
  endfunction
  function automatic logic ot_ok(input logic [7:0] v);
    return v inside {8'h22, 8'h36, 8'hc0, 8'hd6, 8'he2, 8'hf6, 8'hf9};
  endfunction
  function automatic logic vin_ok(input logic [7:0] v);
    return v inside {8'h00, 8'h16, 8'h22, 8'h36, 8'hb8, 8'hc0, 8'hd6, 8'he2, 8'hf6};
  endfunction
  // ============================================================
  // comparison, verdict and access tasks
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic e);
    pfl_host_i.xfer(1'b1, c, d, ak, nk, q);
    chk(ak, e);
    chk(nk, !e);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    pfl_host_i.xfer(1'b0, c, 16'h0000, ak, nk, q);
    chk(ak, 1'b1);
    chk(q, e);
  endtask
  // bounded wait on the power stage enable; running out ends the run
  task automatic wait_out(input logic v);
    for (int n = 0; n < 20 && output_en_q !== v; n++)
      tick(1);
    chk(output_en_q, v);
    if (output_en_q !== v)
      tally_and_finish();
  endtask
  // ============================================================
  // main sequence
  initial
  begin
    logic [15:0] v, m;
    v = 16'($urandom(23));
    tick(12);
    reset = 1'b0;
    for (int i = 0; i < 12; i++)
      rd(codes[i], defs[i]);
    wr(8'h4b, 16'h1234, 1'b0);
    pfl_host_i.xfer(1'b0, 8'h62, 16'h0000, ak, nk, q);
    chk(nk, 1'b1);
    m = 16'h007d;
    for (int i = 0; i < 10; i++)
    begin
      v = (i == 0) ? 16'h0096 : (i == 1) ? 16'h0097 : 16'($urandom_range(0, 300));
      wr(8'h4f, v, lim_ok(v));
      m = lim_ok(v) ? v : m;
      rd(8'h4f, m);
    end
    for (int i = 0; i < 8; i++)
      wr(8'h50, {8'h00, otc[i]}, ot_ok(otc[i]));
    rd(8'h50, 16'h00f9);
    for (int i = 0; i < 10; i++)
      wr(8'h56, {8'h00, vic[i]}, vin_ok(vic[i]));
    rd(8'h56, 16'h00b8);
    for (int i = 0; i < 8; i++)
    begin
      v = 16'($urandom);
      wr(anyc[i % 4], v, 1'b1);
      rd(anyc[i % 4], v);
    end
    wr(8'h4f, 16'h007d, 1'b1);
    // sequencer: over-temperature retries, off commands, bias, faults
    enable_pin = 1;
    operation_on = 1;
    wait_out(1);
    repeat (3)
    begin
      temp_reading = 16'h007d;
      tick(3);
      chk(output_en_q, 1'b0);
      chk(ot_fault_q, 1'b1);
      chk(ot_warn_q, 1'b1);
      temp_reading = 16'h007c;
      wait_out(1);
    end
    temp_reading = 16'h0090;
    tick(3);
    operation_on = 0;
    temp_reading = 16'h0019;
    tick(6);
    chk(output_en_q, 1'b0);
    operation_on = 1;
    wait_out(1);
    chk(ot_fault_q, 1'b0);
    chk(ot_warn_q, 1'b0);
    enable_pin = 0;
    wait_out(0);
    tick(3);
    chk(output_en_q, 1'b0);
    enable_pin = 1;
    wait_out(1);
    bias_ok_pin = 0;
    wait_out(0);
    tick(3);
    chk(output_en_q, 1'b0);
    bias_ok_pin = 1;
    wait_out(1);
    other_fault = 1;
    tick(3);
    other_fault = 0;
    tick(6);
    chk(output_en_q, 1'b0);
    clear_faults = 1;
    tick(1);
    clear_faults = 0;
    wait_out(1);
    vin_ov_detect = 1;
    tick(5);
    chk(vin_ov_fault_q, 1'b1);
    chk(output_en_q, 1'b0);
    vin_ov_detect = 0;
    tick(10);
    chk(output_en_q, 1'b0);
    clear_faults = 1;
    tick(1);
    clear_faults = 0;
    wait_out(1);
    chk(vin_ov_fault_q, 1'b0);
    // non-retry temperature code latches off until a clear
    wr(8'h50, 16'h00c0, 1'b1);
    temp_reading = 16'h0080;
    tick(3);
    chk(ot_fault_q, 1'b1);
    temp_reading = 16'h0019;
    tick(6);
    chk(output_en_q, 1'b0);
    clear_faults = 1;
    tick(1);
    clear_faults = 0;
    wait_out(1);
    wr(8'h50, 16'h00f9, 1'b1);
    // ignore code on input over-voltage leaves the output running
    wr(8'h56, 16'h0000, 1'b1);
    vin_ov_detect = 1;
    tick(5);
    chk(vin_ov_fault_q, 1'b0);
    chk(output_en_q, 1'b1);
    vin_ov_detect = 0;
    tick(3);
    wr(8'h56, 16'h00b8, 1'b1);
    // power good hysteresis between the two thresholds
    foreach (defs[i])
    begin
      if (i > 4)
        break;
      vout_reading = (i == 0) ? 16'h0120 : (i == 2) ? 16'h0100 : (i == 4) ? 16'h0115 : 16'h0110;
      tick(3);
      chk(power_good_q, (i == 0 || i == 1 || i == 4));
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ===== sim/pfl_host.sv
// host model issuing single command accesses to the bank
// assumes: one-cycle strobes, answer registered on the taking edge
`timescale 1ns/1ns
`default_nettype none
module pfl_host (
  input  wire logic        ref_clk,
  input  wire logic        cmd_ack_q,
  input  wire logic        cmd_nack_q,
  input  wire logic [15:0] cmd_rdata_q,
  output var logic  [7:0]  cmd_code,
  output var logic         cmd_wr,
  output var logic         cmd_rd,
  output var logic  [15:0] cmd_wdata
);
  initial
  begin
    cmd_code = 8'h00;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_wdata = 16'h0000;
  end
  // ============================================================
  // one access; code and data scrambled after the answer so stale values never help
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic ak, output logic nk, output logic [15:0] q);
    @(posedge ref_clk);
    #1;
    cmd_code = c;
    cmd_wdata = d;
    cmd_wr = w;
    cmd_rd = !w;
    @(posedge ref_clk);
    #1;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    ak = cmd_ack_q;
    nk = cmd_nack_q;
    q = cmd_rdata_q;
    cmd_code = ~c;
    cmd_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// ===== src/pfl_bank.sv
// fault-limit command bank of a digitally managed buck regulator
// assumes: a transaction layer on ref_clk presents decoded command
// accesses; telemetry words arrive on ref_clk; pins are asynchronous
// bank defaults stand in for the non-volatile load at reset
//
// Functional notes
// R1 - over-temperature limit 0 to 150, default 125
// R2 - default response keeps output off during overheating
// R3 - default response restarts when overheating clears
// R4 - retries unlimited until enable or operation off
// R5 - retries end on bias loss or other fault
// R6 - default input over-voltage response is non-standard
// R7 - input over-voltage never restarts automatically
// R8 - output stays off until fault is cleared; other_fault latches only if it hits while on or retrying with bias good
// R9 - power good uses on/off threshold hysteresis
`timescale 1ns/1ns
`default_nettype none
`include "pfl_map.svh"

module pfl_bank #(
  parameter int DATA_W = 16  // command data width
) (
  input  wire logic              ref_clk,         // 25 MHz clock
  input  wire logic              reset,           // synchronous, active high
  // command access from the transaction layer
  input  wire logic [7:0]        cmd_code,        // command code
  input  wire logic              cmd_wr,          // write pulse
  input  wire logic              cmd_rd,          // read pulse
  input  wire logic [DATA_W-1:0] cmd_wdata,       // write data
  output logic [DATA_W-1:0]      cmd_rdata_q,     // read data
  output logic                   cmd_ack_q,       // access accepted
  output logic                   cmd_nack_q,      // unmapped or refused
  // control and telemetry
  input  wire logic              enable_pin,      // enable pin, async
  input  wire logic              bias_ok_pin,     // bias supply good, async
  input  wire logic              vin_ov_detect,   // input comparator, async
  input  wire logic              operation_on,    // operation command on
  input  wire logic              other_fault,     // another fault shutdown
  input  wire logic              clear_faults,    // clear fault pulse
  input  wire logic [DATA_W-1:0] temp_reading,    // temperature, degrees
  input  wire logic [DATA_W-1:0] vout_reading,    // output voltage word
  output logic                   output_en_q,     // power stage enable
  output logic                   power_good_q,    // power good
  output logic                   ot_fault_q,      // over-temperature fault
  output logic                   ot_warn_q,       // over-temperature warning
  output logic                   vin_ov_fault_q   // latched input over-voltage
);

  // ============================================================
  // helper functions

  // command code to bank index, none when unmapped
  // unmapped codes fall to the none index so the port can refuse them
  function automatic logic [3:0] code_to_idx(input logic [7:0] code);
    case (code)
      `PFL_CMD_IOUT_WARN:    return `PFL_IDX_IOUT_WARN;
      `PFL_CMD_OT_FAULT:     return `PFL_IDX_OT_FAULT;
      `PFL_CMD_OT_RESP:      return `PFL_IDX_OT_RESP;
      `PFL_CMD_OT_WARN:      return `PFL_IDX_OT_WARN;
      `PFL_CMD_VIN_OV_FAULT: return `PFL_IDX_VIN_OV_FAULT;
      `PFL_CMD_VIN_OV_RESP:  return `PFL_IDX_VIN_OV_RESP;
      `PFL_CMD_VIN_UV_WARN:  return `PFL_IDX_VIN_UV_WARN;
      `PFL_CMD_IIN_WARN:     return `PFL_IDX_IIN_WARN;
      `PFL_CMD_PG_ON:        return `PFL_IDX_PG_ON;
      `PFL_CMD_PG_OFF:       return `PFL_IDX_PG_OFF;
      `PFL_CMD_TURN_ON_DELAY_TIME:    return `PFL_IDX_TURN_ON_DELAY_TIME;
      `PFL_CMD_TURN_ON_RISE_TIME:     return `PFL_IDX_TURN_ON_RISE_TIME;
      default:               return `PFL_IDX_NONE;
    endcase
  endfunction

  // reset value of each bank entry
  // output current warning has no stored default here, so it powers up at zero
  function automatic logic [15:0] rst_val(input logic [3:0] idx);
    case (idx)
      `PFL_IDX_OT_FAULT:     return `PFL_RST_OT_FAULT;
      `PFL_IDX_OT_RESP:      return `PFL_RST_OT_RESP;
      `PFL_IDX_OT_WARN:      return `PFL_RST_OT_WARN;
      `PFL_IDX_VIN_OV_FAULT: return `PFL_RST_VIN_OV_FAULT;
      `PFL_IDX_VIN_OV_RESP:  return `PFL_RST_VIN_OV_RESP;
      `PFL_IDX_VIN_UV_WARN:  return `PFL_RST_VIN_UV_WARN;
      `PFL_IDX_IIN_WARN:     return `PFL_RST_IIN_WARN;
      `PFL_IDX_PG_ON:        return `PFL_RST_PG_ON;
      `PFL_IDX_PG_OFF:       return `PFL_RST_PG_OFF;
      `PFL_IDX_TURN_ON_DELAY_TIME:    return `PFL_RST_TURN_ON_DELAY_TIME;
      `PFL_IDX_TURN_ON_RISE_TIME:     return `PFL_RST_TURN_ON_RISE_TIME;
      default:               return `PFL_RST_IOUT_WARN;
    endcase
  endfunction

  // response codes that both fault-response commands accept
  function automatic logic resp_shared(input logic [7:0] code);
    return code == `PFL_RESP_C22 || code == `PFL_RESP_C36 || code == `PFL_RESP_CC0 ||
           code == `PFL_RESP_CD6 || code == `PFL_RESP_CE2 || code == `PFL_RESP_CF6;
  endfunction

  // range check: temperature limits above 150 are refused, response
  // bytes must be one of the listed codes
  function automatic logic write_ok(input logic [3:0] idx, input logic [15:0] d);
    case (idx)
      `PFL_IDX_OT_FAULT,
      `PFL_IDX_OT_WARN:     return d <= `PFL_TEMP_MAX;  // [R1]
      `PFL_IDX_OT_RESP:     return d[15:8] == 8'h00 &&
                              (resp_shared(d[7:0]) || d[7:0] == `PFL_RESP_OT_RETRY);
      `PFL_IDX_VIN_OV_RESP: return d[15:8] == 8'h00 &&
                              (resp_shared(d[7:0]) || d[7:0] == `PFL_RESP_IGNORE ||
                               d[7:0] == `PFL_RESP_C16 || d[7:0] == `PFL_RESP_VIN_LATCH);
      `PFL_IDX_NONE:        return 1'b0;
      default:              return 1'b1;
    endcase
  endfunction

  // ============================================================
  // pin synchronisers: stage one feeds stage two only
  // operation_on, other_fault and clear_faults come from ref_clk logic, no sync
  logic [2:0] sync1_q;  // first stage
  logic [2:0] sync2_q;  // second stage, safe to use

  // two flops per asynchronous pin
  // a pin pulse shorter than one clock may be missed; the pins are slow levels
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {vin_ov_detect, bias_ok_pin, enable_pin};
      sync2_q <= sync1_q;
    end
  end

  // ============================================================
  // command decode
  logic [15:0] bank_q [`PFL_BANK_DEPTH];                // command registers
  wire  [3:0]  acc_idx  = code_to_idx(cmd_code);        // decoded index
  wire         acc_hit  = acc_idx != `PFL_IDX_NONE;     // mapped code
  // a write lands only for a mapped code with a value in range
  wire         wr_good  = cmd_wr && write_ok(acc_idx, cmd_wdata);
  wire         bad_acc  = (cmd_wr && !wr_good) || (cmd_rd && !acc_hit);
  // unmapped reads give zero here and are refused at the port
  wire [15:0]  rd_word  = acc_hit ? bank_q[acc_idx] : 16'h0000;

  // bank storage, defaults as loaded from non-volatile memory;
  // every entry resets, so a read straight after reset is never unknown
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < `PFL_BANK_DEPTH; i++)
    begin
      if (reset)
        bank_q[i] <= rst_val(4'(i));
      else if (wr_good && acc_idx == 4'(i))
        bank_q[i] <= cmd_wdata;
    end
  end

  // read data and handshake, one-cycle pulses
  // a refused access still answers, so the host never waits on a dead code
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cmd_rdata_q <= '0;
      cmd_ack_q   <= 1'b0;
      cmd_nack_q  <= 1'b0;
    end
    else
    begin
      if (cmd_rd && acc_hit)
        cmd_rdata_q <= rd_word;
      cmd_ack_q  <= (cmd_wr || cmd_rd) && !bad_acc;
      cmd_nack_q <= bad_acc;  // refused write leaves the old value
    end
  end

  // ============================================================
  // fault detection
  // temperature is compared as a raw unsigned word: exponent bits are
  // ignored, so the host must write limits in whole degrees
  // the comparisons run every cycle, so a limit write acts at once
  wire [7:0] ot_resp   = bank_q[`PFL_IDX_OT_RESP][7:0];
  wire [7:0] vin_resp  = bank_q[`PFL_IDX_VIN_OV_RESP][7:0];
  wire       ot_now    = temp_reading >= bank_q[`PFL_IDX_OT_FAULT];  // [R1]
  wire       ow_now    = temp_reading >= bank_q[`PFL_IDX_OT_WARN];
  wire       vin_ov    = sync2_q[`PFL_SYNC_VIN_OV] && vin_resp != `PFL_RESP_IGNORE;
  wire       cmd_on    = sync2_q[`PFL_SYNC_EN] && operation_on;
  wire       bias_ok   = sync2_q[`PFL_SYNC_BIAS];
  wire       ot_retry  = ot_resp == `PFL_RESP_OT_RETRY;
  // every non-ignore input response latches here; the default one differs
  // from the standard only by never retrying, so one path serves both
  wire       vin_latch = vin_ov || vin_ov_fault_q;  // [R6]

  // latched input over-voltage; a new event beats a clear in the same cycle
  // the flag is what the host sees; only clear_faults lowers it
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      vin_ov_fault_q <= 1'b0;
    else if (vin_ov)
      vin_ov_fault_q <= 1'b1;  // [R8]
    else if (clear_faults)
      vin_ov_fault_q <= 1'b0;
  end

  // live temperature status flags
  // these follow the reading, with no hysteresis of their own
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ot_fault_q <= 1'b0;
      ot_warn_q  <= 1'b0;
    end
    else
    begin
      ot_fault_q <= ot_now;
      ot_warn_q  <= ow_now;
    end
  end

  // ============================================================
  // output sequencer
  pfl_pkg::pfl_state_t state_q;  // current state
  pfl_pkg::pfl_state_t state_d;  // next state

  // next state: bias loss and other faults take priority over retrying
  // an off command is checked before temperature so it always ends retries
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      // off: start only when every cause to stay off is gone
      pfl_pkg::PFL_ST_OFF:
        if (cmd_on && bias_ok && !other_fault && !vin_latch && !ot_now)
          state_d = pfl_pkg::PFL_ST_ON;
      // on: causes in priority order, bias first
      pfl_pkg::PFL_ST_ON:
        if (!bias_ok)
          state_d = pfl_pkg::PFL_ST_OFF;                            // [R5]
        else if (other_fault || vin_latch)
          state_d = pfl_pkg::PFL_ST_LATCHED;                        // [R5] [R7]
        else if (!cmd_on)
          state_d = pfl_pkg::PFL_ST_OFF;
        else if (ot_now)
          state_d = ot_retry ? pfl_pkg::PFL_ST_OT_WAIT              // [R2]
                             : pfl_pkg::PFL_ST_LATCHED;
      // over-temperature wait: the retry count is unlimited on purpose
      pfl_pkg::PFL_ST_OT_WAIT:
        if (!bias_ok)
          state_d = pfl_pkg::PFL_ST_OFF;                            // [R5]
        else if (other_fault || vin_latch)
          state_d = pfl_pkg::PFL_ST_LATCHED;                        // [R5]
        else if (!cmd_on)
          state_d = pfl_pkg::PFL_ST_OFF;                            // [R4]
        else if (!ot_now)
          state_d = pfl_pkg::PFL_ST_ON;                             // [R3]
      pfl_pkg::PFL_ST_LATCHED:
        // no automatic restart; only a clear, once the cause is gone
        if (clear_faults && !vin_ov && !other_fault)
          state_d = pfl_pkg::PFL_ST_OFF;                            // [R7] [R8]
      // illegal code: fall back to the safe off state
      default:
        state_d = pfl_pkg::PFL_ST_OFF;
    endcase
  end

  // state register and output enable, registered for a clean pin
  // the enable follows the next state, so it moves in step with state_q
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_q     <= pfl_pkg::PFL_ST_OFF;
      output_en_q <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      output_en_q <= state_d == pfl_pkg::PFL_ST_ON;                 // [R2]
    end
  end

  // ============================================================
  // power good with hysteresis between the two thresholds
  // it runs whether or not the output is enabled
  wire pg_rise = vout_reading > bank_q[`PFL_IDX_PG_ON];
  wire pg_fall = vout_reading < bank_q[`PFL_IDX_PG_OFF];

  // holds its level inside the band, so noise cannot chatter it
  // if the off threshold is set above the on threshold, off wins
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      power_good_q <= 1'b0;
    else if (pg_fall)
      power_good_q <= 1'b0;                                         // [R9]
    else if (pg_rise)
      power_good_q <= 1'b1;                                         // [R9]
  end

endmodule
`default_nettype wire

// ===== src/pfl_map.svh
// command codes, reset values and limits of the fault-limit command bank
// assumes: included by bare name from the package and the bank module
`ifndef PFL_MAP_SVH
`define PFL_MAP_SVH

// ============================================================
// command codes
`define PFL_CMD_IOUT_WARN    8'h4a
`define PFL_CMD_OT_FAULT     8'h4f
`define PFL_CMD_OT_RESP      8'h50
`define PFL_CMD_OT_WARN      8'h51
`define PFL_CMD_VIN_OV_FAULT 8'h55
`define PFL_CMD_VIN_OV_RESP  8'h56
`define PFL_CMD_VIN_UV_WARN  8'h58
`define PFL_CMD_IIN_WARN     8'h5d
`define PFL_CMD_PG_ON        8'h5e
`define PFL_CMD_PG_OFF       8'h5f
`define PFL_CMD_TURN_ON_DELAY_TIME    8'h60
`define PFL_CMD_TURN_ON_RISE_TIME     8'h61

// ============================================================
// register indices inside the bank
`define PFL_IDX_IOUT_WARN    4'h0
`define PFL_IDX_OT_FAULT     4'h1
`define PFL_IDX_OT_RESP      4'h2
`define PFL_IDX_OT_WARN      4'h3
`define PFL_IDX_VIN_OV_FAULT 4'h4
`define PFL_IDX_VIN_OV_RESP  4'h5
`define PFL_IDX_VIN_UV_WARN  4'h6
`define PFL_IDX_IIN_WARN     4'h7
`define PFL_IDX_PG_ON        4'h8
`define PFL_IDX_PG_OFF       4'h9
`define PFL_IDX_TURN_ON_DELAY_TIME    4'ha
`define PFL_IDX_TURN_ON_RISE_TIME     4'hb
`define PFL_IDX_NONE         4'hf
`define PFL_BANK_DEPTH       12

// ============================================================
// reset (non-volatile default) values
`define PFL_RST_IOUT_WARN    16'h0000
`define PFL_RST_OT_FAULT     16'h007d
`define PFL_RST_OT_RESP      16'h00f9
`define PFL_RST_OT_WARN      16'h0069
`define PFL_RST_VIN_OV_FAULT 16'hf81e
`define PFL_RST_VIN_OV_RESP  16'h00b8
`define PFL_RST_VIN_UV_WARN  16'hf812
`define PFL_RST_IIN_WARN     16'hf80a
`define PFL_RST_PG_ON        16'h0114
`define PFL_RST_PG_OFF       16'h0105
`define PFL_RST_TURN_ON_DELAY_TIME    16'h0000
`define PFL_RST_TURN_ON_RISE_TIME     16'h0005

// ============================================================
// limits and response codes
`define PFL_TEMP_MAX         16'h0096
`define PFL_RESP_OT_RETRY    8'hf9
`define PFL_RESP_VIN_LATCH   8'hb8
`define PFL_RESP_IGNORE      8'h00
`define PFL_RESP_C16         8'h16
`define PFL_RESP_C22         8'h22
`define PFL_RESP_C36         8'h36
`define PFL_RESP_CC0         8'hc0
`define PFL_RESP_CD6         8'hd6
`define PFL_RESP_CE2         8'he2
`define PFL_RESP_CF6         8'hf6
`define PFL_SYNC_EN          0
`define PFL_SYNC_BIAS        1
`define PFL_SYNC_VIN_OV      2

`endif

// ===== src/pfl_pkg.sv
// types shared by the fault-limit command bank
// assumes: pfl_map.svh is on the include path
`include "pfl_map.svh"

package pfl_pkg;

  // ============================================================
  // output sequencer states, one-hot
  typedef enum logic [3:0] {
    PFL_ST_OFF     = 4'h1,  // output commanded off
    PFL_ST_ON      = 4'h2,  // regulating
    PFL_ST_OT_WAIT = 4'h4,  // over-temperature, waiting to restart
    PFL_ST_LATCHED = 4'h8   // latched off until faults cleared
  } pfl_state_t;

endpackage
